// *** inc/pmc_pkg.sv ***
// Constants and types of the power monitor register block
package pmc_pkg;
    // Command codes of the registers
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_SHUNT = 8'h01;
    localparam logic [7:0] REG_RAIL = 8'h02;
    localparam logic [7:0] REG_PWR = 8'h03;
    localparam logic [7:0] REG_CUR = 8'h04;
    localparam logic [7:0] REG_CAL = 8'h05;
    localparam logic [7:0] REG_MSK = 8'h06;
    localparam logic [7:0] REG_LIM = 8'h07;
    localparam logic [7:0] REG_MAKER = 8'hFE;
    localparam logic [7:0] REG_DIE = 8'hFF;
    localparam logic [7:0] REG_WORDS = 8'h08;
    // Reset values of the configuration and result words, and write mask of the configuration word
    localparam logic [15:0] CFG_RST = 16'h4127;
    localparam logic [15:0] RES_RST = 16'h0000;
    localparam logic [15:0] CFG_WMASK = 16'h7FFF;
    // Identity words, values arbitrary
    localparam logic [15:0] MAKER_ID = 16'h00A5;
    localparam logic [15:0] DIE_IDENTITY = 16'h0001;
    // Seven-bit link address
    localparam logic [6:0] DEV_ADDR = 7'h40;
    // Field positions of the configuration word
    localparam int CFG_SWRST_BIT = 15;
    localparam int AVG_LSB = 9;
    localparam int RAIL_CT_LSB = 6;
    localparam int SHUNT_CT_LSB = 3;
    localparam int MODE_LSB = 0;
    localparam int MODE_SHUNT_BIT = 0;
    localparam int MODE_RAIL_BIT = 1;
    localparam int MODE_CONT_BIT = 2;
    // Timing: clock rate, link timeout and conversion times
    localparam int unsigned CLK_MHZ_DEF = 100;
    localparam int unsigned TMO_MS = 37;
    localparam int unsigned CONV_US [8] = '{139, 203, 269, 525, 1037, 2061, 4109, 8205};
    // Averaging counts 1,4,16,64,128,256,512,1024 as shifts
    localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
    // Converter sequencer and link phases
    typedef enum logic [1:0] {CV_IDLE, CV_SHUNT, CV_RAIL} pmc_conv_e;
    typedef enum logic [2:0] {LK_ADDR, LK_PTR, LK_WHI, LK_WLO, LK_RD, LK_IGN} pmc_link_e;
endpackage : pmc_pkg

// *** src/pmc_monitor.sv ***
// Register bank, conversion sequencer and two-wire slave of the power monitor
`timescale 1ns/1ps
// How it works
// - Each register is a 16-bit word moved over the link as a high byte then a low byte.
// - The configuration word at 00h is read/write and resets to 4127h.
// - Result words 01h to 04h are read-only and reset to zero.
// - Reading the configuration word never disturbs settings; its repeated start briefly holds and restarts a running conversion.
// - A write of the configuration word halts conversion until the frame ends.
// - A finished configuration write starts a new conversion with the new settings.
// - Writing bit 15 of the configuration restores all defaults and the bit reads back zero.
// - Bits 11:9 choose averaging of 1, 4, 16, 64, 128, 256, 512 or 1024 samples.
// - Bits 8:6 choose the rail conversion time from 139 us to 8205 us.
// - Bits 5:3 choose the shunt conversion time with the same table.
// - Shunt and rail use their own times and share the averaging count.
// - The mode bits decide which inputs are sampled.
// - Mode 000/100 is off, 001-011 triggered, 101-111 continuous, bit0 shunt, bit1 rail.
// - The shunt result is kept as a signed two's-complement word.
// - With averaging the shunt and rail words hold the mean of the samples; power and current hold the inputs at the last sample.
module pmc_monitor #(
    parameter int unsigned CLK_MHZ = pmc_pkg::CLK_MHZ_DEF
) (
    // System clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Two-wire link
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Converter samples and derived values
    input wire logic [15:0] shunt_drop_value,
    input wire logic [15:0] supply_rail_value,
    input wire logic [15:0] power_value,
    input wire logic [15:0] current_value,
    output logic adc_start,
    output logic adc_rail_sel,
    // Settings for the arithmetic and alert logic
    output logic [15:0] current_scale_q,
    output logic [15:0] alarm_mask_enable_q,
    output logic [15:0] alarm_threshold_q
);
    import pmc_pkg::*;

    localparam int unsigned TMO_CYC = TMO_MS * 1000 * CLK_MHZ;

    // System side state
    logic tmo_q;
    logic [31:0] tmo_cnt_q;
    logic req_q;
    logic pend_q;
    logic [15:0] pub_q [8];
    logic [15:0] live [8];
    logic [15:0] measurement_config_q;
    logic [15:0] shunt_drop_result_q;
    logic [15:0] supply_rail_result_q;
    logic [15:0] computed_power_q;
    logic [15:0] computed_current_q;
    logic [2:0] wr_s;
    logic [1:0] bsy_s;
    logic [1:0] sta_s;
    logic [1:0] sto_s;
    logic [1:0] scl_s;
    logic [1:0] ack_s;
    pmc_conv_e st_q;
    pmc_conv_e st_d;
    logic [23:0] tmr_q;
    logic [10:0] smp_q;
    logic signed [25:0] acc_q;

    // Link side state
    logic st_any_t;
    logic start_t;
    logic stop_t;
    logic st_seen_q;
    logic ack_q;
    logic rd_lo_q;
    logic cfg_busy_q;
    logic wr_t_q = 1'b0;
    logic mack_q;
    logic rq_s1;
    logic rq_s2;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] ptr_q;
    logic [7:0] hi_q;
    logic [7:0] wr_ptr_q;
    logic [15:0] wr_dat_q;
    logic [15:0] mir_q [8];
    pmc_link_e ph_q;

    // Link decode
    wire new_frm = st_any_t != st_seen_q;
    wire [3:0] bit_n = new_frm ? 4'h0 : cnt_q;
    wire [7:0] sh_n = {sh_q[6:0], sda_i};
    wire byte_end = bit_n == 4'h7;
    wire ack_slot = bit_n == 4'h8;
    wire adr_hit = sh_n[7:1] == DEV_ADDR;
    pmc_link_e ph_n;
    pmc_link_e ph_nx;
    logic ack_nx;
    wire mir_ld = rq_s2 != mack_q && ph_n != LK_RD;
    assign ph_n = new_frm ? LK_ADDR : ph_q;
    assign ph_nx = ph_n == LK_ADDR ? (!adr_hit ? LK_IGN : sh_n[0] ? LK_RD : LK_PTR)
                 : (ph_n == LK_PTR || ph_n == LK_WLO) ? LK_WHI
                 : ph_n == LK_WHI ? LK_WLO : ph_n;
    assign ack_nx = ph_n == LK_ADDR ? adr_hit : (ph_n inside {LK_PTR, LK_WHI, LK_WLO});

    // Read word selection, high byte first
    wire [15:0] rd_word = ptr_q == REG_MAKER ? MAKER_ID
                        : ptr_q == REG_DIE ? DIE_IDENTITY
                        : ptr_q < REG_WORDS ? mir_q[ptr_q[2:0]] : RES_RST;
    wire [7:0] rd_byte = rd_lo_q ? rd_word[7:0] : rd_word[15:8];
    wire [2:0] bit_sel = 3'h7 - cnt_q[2:0];
    wire drv_low = !new_frm && (cnt_q == 4'h8 ? ack_q : (ph_q == LK_RD && !rd_byte[bit_sel]));

    // Start and stop detection on the data line
    always_ff @(negedge sda_i or posedge tmo_q) begin
        if (tmo_q) begin
            st_any_t <= 1'b0;
            start_t <= 1'b0;
        end else if (scl_clk) begin
            st_any_t <= ~st_any_t;
            if (start_t == stop_t) begin
                start_t <= ~start_t;
            end
        end
    end
    always_ff @(posedge sda_i or posedge tmo_q) begin
        if (tmo_q) begin
            stop_t <= 1'b0;
        end else if (scl_clk) begin
            stop_t <= start_t;
        end
    end

    // Bit counter and shifter
    always_ff @(posedge scl_clk or posedge tmo_q) begin
        if (tmo_q) begin
            st_seen_q <= 1'b0;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
        end else begin
            st_seen_q <= st_any_t;
            cnt_q <= ack_slot ? 4'h0 : bit_n + 4'h1;
            sh_q <= sh_n;
        end
    end

    // Transfer phase and acknowledge
    always_ff @(posedge scl_clk or posedge tmo_q) begin
        if (tmo_q) begin
            ph_q <= LK_IGN;
            ack_q <= 1'b0;
            rd_lo_q <= 1'b0;
        end else if (byte_end) begin
            ph_q <= ph_nx;
            ack_q <= ack_nx;
            // Preset so the address acknowledge flips it to the high byte
            if (ph_n == LK_ADDR) begin
                rd_lo_q <= 1'b1;
            end
        end else if (ack_slot) begin
            ack_q <= 1'b0;
            if (ph_n == LK_RD) begin
                ph_q <= sda_i ? LK_IGN : LK_RD;
                rd_lo_q <= ~rd_lo_q;
            end
        end else begin
            ph_q <= ph_n;
        end
    end

    // Pointer and write word capture
    always_ff @(posedge scl_clk or posedge tmo_q) begin
        if (tmo_q) begin
            ptr_q <= 8'h00;
            hi_q <= 8'h00;
            cfg_busy_q <= 1'b0;
        end else begin
            if (byte_end && ph_n == LK_PTR) begin
                ptr_q <= sh_n;
            end
            if (byte_end && ph_n == LK_WHI) begin
                hi_q <= sh_n;
            end
            if (new_frm) begin
                cfg_busy_q <= 1'b0;
            end else if (bit_n == 4'h0 && ph_q == LK_WHI && ptr_q == REG_CFG) begin
                cfg_busy_q <= 1'b1;
            end
        end
    end

    // Completed word handed to the system side; toggle kept across timeouts
    always_ff @(posedge scl_clk) begin
        if (byte_end && ph_n == LK_WLO) begin
            wr_ptr_q <= ptr_q;
            wr_dat_q <= {hi_q, sh_n};
            wr_t_q <= ~wr_t_q;
        end
    end

    // Snapshot handshake, frozen while a word is being read out
    always_ff @(posedge scl_clk or posedge tmo_q) begin
        if (tmo_q) begin
            rq_s1 <= 1'b0;
            rq_s2 <= 1'b0;
            mack_q <= 1'b0;
        end else begin
            rq_s1 <= req_q;
            rq_s2 <= rq_s1;
            if (mir_ld) begin
                mack_q <= rq_s2;
            end
        end
    end
    always_ff @(posedge scl_clk) begin
        if (mir_ld) begin
            mir_q <= pub_q;
        end
    end

    // Data line driver
    always_ff @(negedge scl_clk or posedge tmo_q) begin
        if (tmo_q) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= drv_low;
        end
    end

    // Synchronisers into the system clock
    always_ff @(posedge clk) begin
        wr_s <= {wr_s[1:0], wr_t_q};
        bsy_s <= {bsy_s[0], cfg_busy_q};
        sta_s <= {sta_s[0], start_t};
        sto_s <= {sto_s[0], stop_t};
        scl_s <= {scl_s[0], scl_clk};
        ack_s <= {ack_s[0], mack_q};
        sda_o <= 1'b0;
    end

    // System side decode
    wire wr_ev = wr_s[1] ^ wr_s[2];
    wire frm_s = sta_s[1] ^ sto_s[1];
    wire hold = bsy_s[1] & frm_s;
    wire wr_cfg = wr_ev && wr_ptr_q == REG_CFG;
    wire sw_rst = wr_cfg && wr_dat_q[CFG_SWRST_BIT];
    wire clr = sys_rst || sw_rst;
    assign live = '{measurement_config_q, shunt_drop_result_q, supply_rail_result_q, computed_power_q,
                    computed_current_q, current_scale_q, alarm_mask_enable_q, alarm_threshold_q};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tmo_q <= 1'b1;
            tmo_cnt_q <= 32'h0;
        end else if (scl_s[1] || !frm_s) begin
            tmo_q <= 1'b0;
            tmo_cnt_q <= 32'h0;
        end else if (tmo_cnt_q >= TMO_CYC) begin
            tmo_q <= 1'b1;
        end else begin
            tmo_cnt_q <= tmo_cnt_q + 32'h1;
        end
    end

    // Publish register snapshot to the link
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_q <= 1'b0;
        end else if (req_q == ack_s[1]) begin
            req_q <= ~req_q;
        end
    end
    always_ff @(posedge clk) begin
        if (req_q == ack_s[1]) begin
            pub_q <= live;
        end
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            measurement_config_q <= CFG_RST;
        end else if (wr_cfg) begin
            measurement_config_q <= wr_dat_q & CFG_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            current_scale_q <= RES_RST;
            alarm_mask_enable_q <= RES_RST;
            alarm_threshold_q <= RES_RST;
        end else if (wr_ev) begin
            if (wr_ptr_q == REG_CAL) current_scale_q <= wr_dat_q;
            if (wr_ptr_q == REG_MSK) alarm_mask_enable_q <= wr_dat_q;
            if (wr_ptr_q == REG_LIM) alarm_threshold_q <= wr_dat_q;
        end
    end

    // Converter settings decode
    wire [2:0] mode = measurement_config_q[MODE_LSB +: 3];
    wire do_sh = mode[MODE_SHUNT_BIT];
    wire do_rl = mode[MODE_RAIL_BIT];
    wire cont = mode[MODE_CONT_BIT];
    wire go = st_q == CV_IDLE && pend_q && !hold;
    wire tick = st_q != CV_IDLE && tmr_q == 24'h0;
    wire [3:0] shift = AVG_SHIFT[measurement_config_q[AVG_LSB +: 3]];
    wire [10:0] last_n = 11'((32'h1 << shift) - 32'h1);
    wire last = tick && smp_q == last_n;
    wire signed [15:0] smp_raw = signed'(st_q == CV_RAIL ? supply_rail_value : shunt_drop_value);
    wire signed [25:0] smp_v = 26'(smp_raw);
    wire signed [25:0] acc_n = acc_q + smp_v;
    wire signed [25:0] avg_w = acc_n >>> shift;
    wire ld = st_d != CV_IDLE && (st_q == CV_IDLE || tick);
    wire [2:0] ct_idx = st_d == CV_RAIL ? measurement_config_q[RAIL_CT_LSB +: 3]
                                        : measurement_config_q[SHUNT_CT_LSB +: 3];
    wire [23:0] ct_cyc = 24'(CONV_US[ct_idx] * CLK_MHZ - 1);

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            CV_IDLE: if (go && (do_sh || do_rl)) st_d = do_sh ? CV_SHUNT : CV_RAIL;
            CV_SHUNT: if (last) st_d = do_rl ? CV_RAIL : (cont ? CV_SHUNT : CV_IDLE);
            CV_RAIL: if (last) st_d = !cont ? CV_IDLE : (do_sh ? CV_SHUNT : CV_RAIL);
        endcase
        if (hold || clr) st_d = CV_IDLE;
    end

    // Sequencer state and pending start
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= CV_IDLE;
            pend_q <= 1'b1;
        end else begin
            st_q <= st_d;
            if (wr_cfg || (hold && st_q != CV_IDLE)) pend_q <= 1'b1;
            else if (go) pend_q <= 1'b0;
        end
    end

    // Conversion timer and converter strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tmr_q <= 24'h0;
            adc_start <= 1'b0;
            adc_rail_sel <= 1'b0;
        end else begin
            tmr_q <= ld ? ct_cyc : (tmr_q != 24'h0 ? tmr_q - 24'h1 : tmr_q);
            adc_start <= ld;
            if (ld) adc_rail_sel <= st_d == CV_RAIL;
        end
    end

    // Sample accumulator
    always_ff @(posedge clk) begin
        if (sys_rst || st_d == CV_IDLE || last) begin
            acc_q <= 26'sh0;
            smp_q <= 11'h0;
        end else if (tick) begin
            acc_q <= acc_n;
            smp_q <= smp_q + 11'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            shunt_drop_result_q <= RES_RST;
            supply_rail_result_q <= RES_RST;
            computed_power_q <= RES_RST;
            computed_current_q <= RES_RST;
        end else if (last) begin
            if (st_q == CV_SHUNT) shunt_drop_result_q <= avg_w[15:0];
            else supply_rail_result_q <= avg_w[15:0];
            computed_power_q <= power_value;
            computed_current_q <= current_value;
        end
    end
endmodule : pmc_monitor

// *** sim/pmc_host.sv ***
// Two-wire host model that drives the link clock and data line
`timescale 1ns/1ps
module pmc_host (
    // Link wires
    output logic scl_clk,
    output logic sda_h,
    input wire logic sda_w,
    // Read results and acknowledge status
    output logic [15:0] rd_word,
    output logic rd_tgl,
    output logic nak
);
    import pmc_pkg::*;
    logic b;
    // Idle link: clock stands high, data released
    initial begin
        scl_clk = 1'b1;
        sda_h = 1'b1;
        rd_tgl = 1'b0;
        nak = 1'b0;
        rd_word = 16'h0000;
    end
    // One 48 ns bit, data changed while the clock is low
    task automatic clk_bit(input logic v, output logic s);
        sda_h = v;
        #12 scl_clk = 1'b1;
        #12 s = sda_w;
        #12 scl_clk = 1'b0;
        #12;
    endtask : clk_bit
    // Start or repeated start
    task automatic start;
        sda_h = 1'b1;
        #12 scl_clk = 1'b1;
        #12 sda_h = 1'b0;
        #12 scl_clk = 1'b0;
        #12;
    endtask : start
    // Stop, then the clock stands still
    task automatic stop;
        sda_h = 1'b0;
        #12 scl_clk = 1'b1;
        #12 sda_h = 1'b1;
        #24;
    endtask : stop
    task automatic send(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) clk_bit(v[i], b);
        clk_bit(1'b1, b);
        if (b) nak = 1'b1;
    endtask : send
    // word as high byte then low byte
    task automatic write_word(input logic [7:0] p, input logic [15:0] w);
        start();
        send({DEV_ADDR, 1'b0});
        send(p);
        send(w[15:8]);
        send(w[7:0]);
        stop();
    endtask : write_word
    // pointer, repeated start, two bytes, final byte refused
    task automatic read_word(input logic [7:0] p);
        start();
        send({DEV_ADDR, 1'b0});
        send(p);
        start();
        send({DEV_ADDR, 1'b1});
        for (int i = 15; i >= 0; i--) begin
            clk_bit(1'b1, b);
            rd_word[i] = b;
            if (i == 8 || i == 0) clk_bit(i == 0, b);
        end
        stop();
        rd_tgl = ~rd_tgl;
    endtask : read_word
endmodule : pmc_host

// *** sim/pmc_monitor_asserts.sv ***
// Port checker of the power monitor block
`timescale 1ns/1ps
module pmc_monitor_asserts #(
    parameter int unsigned CLK_MHZ = 100
) (
    // Clock, reset and link
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_clk,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Converter control and settings
    input wire logic adc_start,
    input wire logic adc_rail_sel,
    input wire logic [15:0] current_scale_q,
    input wire logic [15:0] alarm_mask_enable_q,
    input wire logic [15:0] alarm_threshold_q
);
    import pmc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [15:0] gap_q;
    logic [4:0] idle_q;
    logic prev_q;
    logic busy_q;
    // Interval since last start, link activity since then, cycles since clock low
    always_ff @(posedge clk) begin
        gap_q <= adc_start ? 16'h0001 : gap_q + 16'h0001;
        prev_q <= !sys_rst && (prev_q || adc_start);
        busy_q <= !sys_rst && !adc_start && (busy_q || !scl_clk);
        idle_q <= !scl_clk ? 5'h00 : idle_q + 5'(idle_q != 5'h1F);
    end
    // Interval matches one of the conversion times
    function automatic logic gap_ok(input logic [15:0] g);
        logic ok;
        ok = 1'b0;
        for (int k = 0; k < 8; k++) if (g >= CONV_US[k] * CLK_MHZ && g <= CONV_US[k] * CLK_MHZ + 2) ok = 1'b1;
        return ok;
    endfunction : gap_ok
    sequence s_start_soon;
        ##[0:4] adc_start;
    endsequence
    sequence s_pulse;
        adc_start ##1 !adc_start;
    endsequence
    a_first_start: assert property ($fell(sys_rst) |-> s_start_soon) else $error("no start after reset");
    a_start_pulse: assert property (adc_start |-> s_pulse) else $error("start too long");
    // input choice moves at a start
    a_sel_moves: assert property ($changed(adc_rail_sel) |-> adc_start || idle_q < 5'h14) else $error("sel moved");
    a_gap_table: assert property (adc_start && prev_q && !busy_q |-> gap_ok(gap_q)) else $error("bad interval");
    a_oe_rise: assert property ($rose(sda_oe) |-> !scl_clk) else $error("data rose at high clock");
    a_oe_fall: assert property ($fell(sda_oe) |-> !scl_clk) else $error("data fell at high clock");
    a_sda_low: assert property (!sda_o) else $error("data value high");
    // settings change only with the link
    a_reg_quiet: assert property ($changed(current_scale_q) || $changed(alarm_mask_enable_q)
        || $changed(alarm_threshold_q) |-> idle_q < 5'h14) else $error("setting changed idle");
    a_reset_vals: assert property (disable iff (1'b0) sys_rst |=> !adc_start && current_scale_q == 16'h0000
        && alarm_threshold_q == 16'h0000) else $error("reset values");
endmodule : pmc_monitor_asserts
bind pmc_monitor pmc_monitor_asserts #(.CLK_MHZ(CLK_MHZ)) pmc_monitor_asserts_i (.clk(clk), .sys_rst(sys_rst),
    .scl_clk(scl_clk), .sda_o(sda_o), .sda_oe(sda_oe), .adc_start(adc_start), .adc_rail_sel(adc_rail_sel),
    .current_scale_q(current_scale_q), .alarm_mask_enable_q(alarm_mask_enable_q),
    .alarm_threshold_q(alarm_threshold_q));

// *** sim/pmc_monitor_test.sv ***
// Self-checking bench of the power monitor block
`timescale 1ns/1ps
module pmc_monitor_test;
    import pmc_pkg::*;
    localparam logic [7:0] ADR [11] = '{REG_SHUNT, REG_RAIL, REG_PWR, REG_CUR, REG_CFG, REG_CAL, REG_MSK,
        REG_LIM, REG_MAKER, REG_DIE, REG_WORDS};
    localparam logic [15:0] RST [11] = '{RES_RST, RES_RST, RES_RST, RES_RST, CFG_RST, 16'h0000, 16'h0000,
        16'h0000, MAKER_ID, DIE_IDENTITY, 16'h0000};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic scl_clk, sda_h, sda_w, sda_o, sda_oe, adc_start, adc_rail_sel, rd_tgl, nak;
    logic [15:0] shv = 16'h0000, rlv = 16'h0000, pwv = 16'h0000, cuv = 16'h0000;
    logic [15:0] rd_word, cs_q, am_q, at_q;
    logic [15:0] ws [3];
    logic [15:0] exp_q [$];
    int fail_count = 0, n_checks = 0, cyc = 0, t_last = 0, sh_n = 0, rl_n = 0, g_sr = 0, g_rs = 0;
    logic prev_sel = 1'b0;
    always #5 clk = ~clk;
    // Wired-AND data line with pull-up
    assign sda_w = sda_h & ~sda_oe;
    pmc_monitor #(.CLK_MHZ(1)) pmc_monitor_i (.clk(clk), .sys_rst(sys_rst), .scl_clk(scl_clk), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .shunt_drop_value(shv), .supply_rail_value(rlv), .power_value(pwv),
        .current_value(cuv), .adc_start(adc_start), .adc_rail_sel(adc_rail_sel), .current_scale_q(cs_q),
        .alarm_mask_enable_q(am_q), .alarm_threshold_q(at_q));
    pmc_host pmc_host_i (.scl_clk(scl_clk), .sda_h(sda_h), .sda_w(sda_w), .rd_word(rd_word), .rd_tgl(rd_tgl),
        .nak(nak));
    task automatic cmp16(input string n, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : cmp16
    task automatic give_verdict;
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // Note the expected word, then read it
    task automatic rd(input logic [7:0] p, input logic [15:0] e);
        exp_q.push_back(e);
        pmc_host_i.read_word(p);
    endtask : rd
    // Each read result is matched with the oldest note
    always @(rd_tgl) if ($time > 0) cmp16("read word", exp_q.pop_front(), rd_word);
    // Start log: counts per input and the latest intervals
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (adc_start === 1'b1) begin
            if (adc_rail_sel) rl_n <= rl_n + 1;
            else sh_n <= sh_n + 1;
            if (adc_rail_sel && !prev_sel) g_sr <= cyc - t_last;
            if (!adc_rail_sel && prev_sel) g_rs <= cyc - t_last;
            t_last <= cyc;
            prev_sel <= adc_rail_sel;
        end
    end
    // Hang guard
    initial begin
        #1200000;
        fail_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h671E));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        pmc_host_i.write_word(REG_SHUNT, 16'hFFFF);
        pmc_host_i.write_word(REG_CUR, 16'hFFFF);
        foreach (ADR[i]) rd(ADR[i], RST[i]);
        // writable settings read back and reach outputs
        for (int i = 0; i < 3; i++) begin
            ws[i] = 16'($urandom());
            pmc_host_i.write_word(REG_CAL + 8'(i), ws[i]);
            rd(REG_CAL + 8'(i), ws[i]);
        end
        cmp16("scale", ws[0], cs_q);
        cmp16("mask", ws[1], am_q);
        cmp16("limit", ws[2], at_q);
        pmc_host_i.write_word(REG_CFG, 16'h8207);
        repeat (10) @(posedge clk);
        cmp16("scale", 16'h0000, cs_q);
        rd(REG_CFG, CFG_RST);
        rd(REG_MSK, 16'h0000);
        for (int m = 0; m < 8; m++) begin
            pmc_host_i.write_word(REG_CFG, 16'h0000);
            repeat (300) @(posedge clk);
            sh_n = 0;
            rl_n = 0;
            pmc_host_i.write_word(REG_CFG, 16'(m));
            repeat (700) @(posedge clk);
            cmp16("shunt runs", 16'(m & 1), 16'(m[2] ? int'(sh_n > 1) : sh_n));
            cmp16("rail runs", 16'((m >> 1) & 1), 16'(m[2] ? int'(rl_n > 1) : rl_n));
        end
        pmc_host_i.write_word(REG_CFG, 16'h0000);
        repeat (300) @(posedge clk);
        for (int a = 0; a < 3; a++) begin
            @(posedge clk);
            shv <= 16'($urandom());
            rlv <= 16'($urandom()) & 16'h7FFF;
            pwv <= 16'($urandom());
            cuv <= 16'($urandom());
            sh_n = 0;
            rl_n = 0;
            pmc_host_i.write_word(REG_CFG, 16'h0003 | 16'(a << 9));
            repeat (278 * (1 << (2 * a)) + 100) @(posedge clk);
            cmp16("shunt samples", 16'(1 << (2 * a)), 16'(sh_n));
            cmp16("rail samples", 16'(1 << (2 * a)), 16'(rl_n));
            rd(REG_SHUNT, shv);
            rd(REG_RAIL, rlv);
            rd(REG_PWR, pwv);
            rd(REG_CUR, cuv);
        end
        // every conversion time, fresh start after the write
        for (int k = 0; k < 8; k++) begin
            pmc_host_i.write_word(REG_CFG, 16'h0007 | 16'(k << 6) | 16'((7 - k) << 3));
            repeat (CONV_US[k] + CONV_US[7 - k] + 60) @(posedge clk);
            cmp16("shunt interval", 16'(CONV_US[7 - k]), 16'(g_sr));
            cmp16("rail interval", 16'(CONV_US[k]), 16'(g_rs));
        end
        repeat (2) @(posedge clk);
        cmp16("ack missing", 16'h0000, 16'(nak));
        cmp16("pending reads", 16'h0000, 16'(exp_q.size()));
        give_verdict();
    end
endmodule : pmc_monitor_test
